// *** logic/imc_map.svh ***
// offsets, field positions, reset values and timing counts of the init config register
// Summary of operation
// [RQ1] writes accepted only in initialization mode
// [RQ2] frame: address/parity byte, then data byte
// [RQ3] all data bits reset to zero
// [RQ4] b7 set: low power needs random code
// [RQ5] b6 clear: master sends parity bit zero
// [RQ6] b6 set: parity bit checked on writes
// [RQ7] b5 clear: interrupt is low pulse
// [RQ8] b5 set: interrupt is steady low level
// [RQ9] b4 picks 100 us or 25 us
// [RQ10] b3 set: pulse at half watchdog, reprogramming
// [RQ11] code 0xx disables resistor check
// [RQ12] code 100: highest resistor, variant three
// [RQ13] code 101: middle resistor, variant two
// [RQ14] code 110: lowest resistor, variant one
`ifndef IMC_MAP_SVH
`define IMC_MAP_SVH

// frame layout
`define IMC_FRAME_BITS 5'h10
`define IMC_CMD_WRITE 2'h1
`define IMC_CMD_READ 2'h0
`define IMC_REG_ADDR 5'h08
`define IMC_READ_HDR 8'h00
`define IMC_PARITY_ODD 1'b1

// data field positions
`define IMC_B_LP_CODE 7
`define IMC_B_PARITY 6
`define IMC_B_INT_LEVEL 5
`define IMC_B_INT_SHORT 4
`define IMC_B_INT_FLASH 3
`define IMC_B_RES_MSB 2
`define IMC_CFG_RESET 8'h00

// resistor check codes
`define IMC_RES_HIGH 3'h4
`define IMC_RES_MID 3'h5
`define IMC_RES_LOW 3'h6

// interrupt pulse timing
`define IMC_CLK_MHZ 25
`define IMC_INT_LONG_US 100
`define IMC_INT_SHORT_US 25
`define IMC_INT_LONG_CYC (`IMC_INT_LONG_US * `IMC_CLK_MHZ)
`define IMC_INT_SHORT_CYC (`IMC_INT_SHORT_US * `IMC_CLK_MHZ)

`endif

// *** logic/imc_pkg.sv ***
// types of the init config register block
package imc_pkg;

	typedef struct packed {
		logic lowpower_entry_code_enable;
		logic parity_enable;
		logic int_level;
		logic int_short;
		logic int_flash;
		logic [2:0] res_code;
	} imc_cfg_t;

	typedef struct packed {
		logic [1:0] cmd;
		logic [4:0] addr;
		logic parity;
		imc_cfg_t data;
	} imc_frame_t;

	typedef enum logic [2:0] {
		SAFE_VARIANT_NONE = 3'h0,
		SAFE_VARIANT_ONE = 3'h1,
		SAFE_VARIANT_TWO = 3'h2,
		SAFE_VARIANT_THREE = 3'h4
	} imc_safe_t;

	typedef enum logic [2:0] {
		SPI_IDLE = 3'h1,
		SPI_SHIFT = 3'h2,
		SPI_EVAL = 3'h4
	} imc_spi_state_t;

endpackage : imc_pkg

// *** logic/imc_pulse.sv ***
// fixed-length pulse timer, ignores start while busy
`timescale 1ns/1ps
module imc_pulse (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// control
	input wire logic start_i,
	input wire logic [11:0] len_i,
	// status
	output logic active_o
);
	logic [11:0] cnt_q;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cnt_q <= 12'h000;
		end else if (start_i && cnt_q == 12'h000) begin
			cnt_q <= len_i;
		end else if (cnt_q != 12'h000) begin
			cnt_q <= cnt_q - 12'h001;
		end
	end

	assign active_o = (cnt_q != 12'h000);

endmodule : imc_pulse

// *** logic/imc_top.sv ***
// init config register with serial write port, interrupt pin and decode
`timescale 1ns/1ps
`include "imc_map.svh"
module imc_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// serial port
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_o,
	output logic spi_err_o,
	// device mode
	input wire logic mode_init_i,
	input wire logic mode_reprog_i,
	// low power entry
	input wire logic lp_req_i,
	input wire logic lp_sel_on_i,
	input wire logic [2:0] lp_code_i,
	input wire logic [2:0] lp_random_i,
	output logic lowpower_regulator_off_o,
	output logic lowpower_regulator_on_o,
	output logic lp_reject_o,
	// interrupt
	input wire logic int_req_i,
	input wire logic wd_half_i,
	input wire logic int_ack_i,
	output logic int_n_o,
	// resistor check
	output logic res_check_en_o,
	output imc_pkg::imc_safe_t safe_variant_o,
	// configuration
	output imc_pkg::imc_cfg_t cfg_o
);
	import imc_pkg::*;

	imc_cfg_t cfg_q;
	imc_spi_state_t st_q;
	logic sclk_q;
	logic cs_n_q;
	logic [15:0] rx_q;
	logic [15:0] tx_q;
	logic [4:0] cnt_q;
	imc_frame_t frame;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_start;
	logic cs_end;
	logic len_ok;
	logic frame_wr;
	logic par_ok;
	logic wr_ok;
	logic err_q;
	logic lp_ok;
	logic lp_off_q;
	logic lp_on_q;
	logic lp_rej_q;
	logic int_event;
	logic pulse_start;
	logic pulse_act;
	logic int_lvl_q;
	logic int_n_q;
	logic [11:0] pulse_len;
	logic res_en_q;
	imc_safe_t safe_q;

	// serial edge detection
	assign sclk_rise = spi_sclk_i & ~sclk_q;
	assign sclk_fall = ~spi_sclk_i & sclk_q;
	assign cs_start = cs_n_q & ~spi_cs_n_i;
	assign cs_end = ~cs_n_q & spi_cs_n_i;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			sclk_q <= spi_sclk_i;
			cs_n_q <= spi_cs_n_i;
		end
	end

	// frame sequencer
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			st_q <= SPI_IDLE;
		end else begin
			case (st_q)
				SPI_IDLE: begin
					if (cs_start) begin
						st_q <= SPI_SHIFT;
					end
				end
				SPI_SHIFT: begin
					if (cs_end) begin
						st_q <= SPI_EVAL;
					end
				end
				SPI_EVAL: begin
					st_q <= SPI_IDLE;
				end
				default: begin
					st_q <= SPI_IDLE;
				end
			endcase
		end
	end

	// receive shifter, msb first on rising clock
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rx_q <= 16'h0000;
			cnt_q <= 5'h00;
		end else if (st_q == SPI_IDLE && cs_start) begin
			rx_q <= 16'h0000;
			cnt_q <= 5'h00;
		end else if (st_q == SPI_SHIFT && sclk_rise) begin
			rx_q <= {rx_q[14:0], spi_mosi_i};
			if (cnt_q != 5'h1f) begin
				cnt_q <= cnt_q + 5'h01;
			end
		end
	end

	// read answer: header byte then register, shifted out on falling clock
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			tx_q <= 16'h0000;
		end else if (st_q == SPI_IDLE && cs_start) begin
			tx_q <= {`IMC_READ_HDR, cfg_q};
		end else if (st_q == SPI_SHIFT && sclk_fall) begin
			tx_q <= {tx_q[14:0], 1'b0};
		end
	end

	assign spi_miso_o = tx_q[15];
	assign spi_miso_oe_o = ~spi_cs_n_i;

	// frame decode
	assign frame = imc_frame_t'(rx_q);
	assign len_ok = (cnt_q == `IMC_FRAME_BITS); // RQ2
	assign frame_wr = len_ok && frame.cmd == `IMC_CMD_WRITE
		&& frame.addr == `IMC_REG_ADDR; // RQ2
	// parity bit ignored while checking is off
	assign par_ok = !cfg_q.parity_enable || ((^rx_q) == `IMC_PARITY_ODD); // RQ6
	assign wr_ok = (st_q == SPI_EVAL) && frame_wr && par_ok && mode_init_i; // RQ1

	// configuration register
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cfg_q <= imc_cfg_t'(`IMC_CFG_RESET); // RQ3
		end else if (wr_ok) begin
			cfg_q <= frame.data; // RQ1
		end
	end

	assign cfg_o = cfg_q;

	// frame error: bad length or bad parity on our address
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			err_q <= 1'b0;
		end else begin
			err_q <= (st_q == SPI_EVAL) && (!len_ok || (frame_wr && !par_ok)); // RQ6
		end
	end

	assign spi_err_o = err_q;

	// low power entry gate
	assign lp_ok = !cfg_q.lowpower_entry_code_enable || (lp_code_i == lp_random_i); // RQ4

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			lp_off_q <= 1'b0;
			lp_on_q <= 1'b0;
			lp_rej_q <= 1'b0;
		end else begin
			lp_off_q <= lp_req_i && lp_ok && !lp_sel_on_i; // RQ4
			lp_on_q <= lp_req_i && lp_ok && lp_sel_on_i; // RQ4
			lp_rej_q <= lp_req_i && !lp_ok;
		end
	end

	assign lowpower_regulator_off_o = lp_off_q;
	assign lowpower_regulator_on_o = lp_on_q;
	assign lp_reject_o = lp_rej_q;

	// interrupt source and shape
	assign int_event = int_req_i
		|| (wd_half_i && cfg_q.int_flash && mode_reprog_i); // RQ10
	assign pulse_start = int_event && !cfg_q.int_level; // RQ7
	assign pulse_len = cfg_q.int_short ? 12'(`IMC_INT_SHORT_CYC)
		: 12'(`IMC_INT_LONG_CYC); // RQ9

	imc_pulse u_int_pulse (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.start_i(pulse_start),
		.len_i(pulse_len),
		.active_o(pulse_act)
	);

	// level hold, event beats acknowledge
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			int_lvl_q <= 1'b0;
		end else if (int_event && cfg_q.int_level) begin
			int_lvl_q <= 1'b1; // RQ8
		end else if (int_ack_i || !cfg_q.int_level) begin
			int_lvl_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			int_n_q <= 1'b1;
		end else begin
			int_n_q <= ~(pulse_act | int_lvl_q); // RQ7 RQ8
		end
	end

	assign int_n_o = int_n_q;

	// resistor check decode
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			res_en_q <= 1'b0;
			safe_q <= SAFE_VARIANT_NONE;
		end else begin
			case (cfg_q.res_code)
				`IMC_RES_HIGH: begin
					res_en_q <= 1'b1;
					safe_q <= SAFE_VARIANT_THREE; // RQ12
				end
				`IMC_RES_MID: begin
					res_en_q <= 1'b1;
					safe_q <= SAFE_VARIANT_TWO; // RQ13
				end
				`IMC_RES_LOW: begin
					res_en_q <= 1'b1;
					safe_q <= SAFE_VARIANT_ONE; // RQ14
				end
				default: begin
					res_en_q <= 1'b0; // RQ11
					safe_q <= SAFE_VARIANT_NONE;
				end
			endcase
		end
	end

	assign res_check_en_o = res_en_q;
	assign safe_variant_o = safe_q;

	// helper: low time of the pin and mode at its fall
	logic [12:0] low_cnt_q;
	logic fall_level_q;
	logic [11:0] fall_len_q;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			low_cnt_q <= 13'h0000;
			fall_level_q <= 1'b0;
			fall_len_q <= 12'h000;
		end else if (!int_n_q) begin
			if (low_cnt_q != 13'h1fff) begin
				low_cnt_q <= low_cnt_q + 13'h0001;
			end
		end else begin
			low_cnt_q <= 13'h0000;
			fall_level_q <= cfg_q.int_level;
			fall_len_q <= pulse_len;
		end
	end

	chk_write_init: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ1
		!mode_init_i |=> $stable(cfg_q))
		else $error("config changed outside init mode");

	chk_frame_len: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ2
		(st_q == SPI_EVAL && cnt_q != `IMC_FRAME_BITS) |=> $stable(cfg_q))
		else $error("config written by short or long frame");

	chk_reset_zero: assert property (@(posedge clk_i) // RQ3
		!resetn_i |=> cfg_q == imc_cfg_t'(`IMC_CFG_RESET))
		else $error("config not zero after reset");

	chk_lp_code: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ4
		(lowpower_regulator_off_o || lowpower_regulator_on_o)
		|-> $past(!cfg_q.lowpower_entry_code_enable || lp_code_i == lp_random_i))
		else $error("low power entered without code");

	chk_parity_bad: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ6
		(st_q == SPI_EVAL && frame_wr && cfg_q.parity_enable
		&& (^rx_q) != `IMC_PARITY_ODD) |=> $stable(cfg_q) ##0 spi_err_o)
		else $error("bad parity write not refused");

	chk_pulse_len: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ7 RQ9
		($rose(int_n_o) && !fall_level_q && $past(!pulse_act))
		|-> low_cnt_q == {1'b0, fall_len_q})
		else $error("interrupt pulse length wrong");

	chk_level_hold: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ8
		(int_lvl_q && cfg_q.int_level && !int_ack_i) |=> ##1 !int_n_o)
		else $error("level interrupt released without ack");

	chk_flash_int: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ10
		(wd_half_i && cfg_q.int_flash && mode_reprog_i) |-> ##2 !int_n_o)
		else $error("no interrupt at half watchdog period");

	chk_res_off: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ11
		!cfg_q.res_code[`IMC_B_RES_MSB] |=> !res_check_en_o
		&& safe_variant_o == SAFE_VARIANT_NONE)
		else $error("resistor check on for code 0xx");

	chk_res_three: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ12
		cfg_q.res_code == `IMC_RES_HIGH |=> res_check_en_o
		&& safe_variant_o == SAFE_VARIANT_THREE)
		else $error("code 100 decode wrong");

	chk_res_two: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ13
		cfg_q.res_code == `IMC_RES_MID |=> res_check_en_o
		&& safe_variant_o == SAFE_VARIANT_TWO)
		else $error("code 101 decode wrong");

	chk_res_one: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ14
		cfg_q.res_code == `IMC_RES_LOW |=> res_check_en_o
		&& safe_variant_o == SAFE_VARIANT_ONE)
		else $error("code 110 decode wrong");

endmodule : imc_top

// *** verif/imc_master.sv ***
// serial master model writing frames msb first
`timescale 1ns/1ps
module imc_master (
	// clock
	input wire logic clk_i,
	// serial lines
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// pm: 0 parity bit zero, 1 odd parity, 2 wrong parity
	// nb: bits sent, msb first, fewer than 16 cuts the frame
	task automatic send(input logic [15:0] f, input logic [1:0] pm, input int nb);
		logic [15:0] w;
		w = f;
		w[8] = (pm == 2'h0) ? 1'b0 : (pm == 2'h1) ? ~^{f[15:9], f[7:0]} : ^{f[15:9], f[7:0]};
		@(negedge clk_i);
		cs_n_o = 1'b0;
		for (int i = 15; i > 15 - nb; i--) begin
			@(negedge clk_i);
			mosi_o = w[i];
			repeat (2) @(negedge clk_i);
			sclk_o = 1'b1;
			repeat (2) @(negedge clk_i);
			sclk_o = 1'b0;
		end
		@(negedge clk_i);
		cs_n_o = 1'b1;
		// released line must not keep the last bit
		mosi_o = ~mosi_o;
		repeat (4) @(negedge clk_i);
	endtask : send
endmodule : imc_master

// *** verif/imc_top_tb.sv ***
// self-checking bench of the init config register
`timescale 1ns/1ps
`include "imc_map.svh"
module imc_top_tb;
	import imc_pkg::*;
	typedef struct packed {
		logic [7:0] data;
		logic en;
		imc_safe_t sv;
	} imc_row_t;
	logic clk_i, resetn_i, sclk, cs_n, mosi, miso, miso_oe, spi_err;
	logic mode_init, mode_reprog, lp_req, lp_sel_on, lp_off, lp_on, lp_rej;
	logic [2:0] lp_code, lp_random;
	logic int_req, wd_half, int_ack, int_n, res_en;
	imc_safe_t safe;
	imc_cfg_t cfg;
	int error_cnt = 0;
	int checks = 0;
	int err_seen = 0;
	int mark, n;
	logic [15:0] rd_sr = 16'h0000;
	imc_row_t rows [6] = '{'{8'h00, 1'b0, SAFE_VARIANT_NONE}, '{8'h04, 1'b1, SAFE_VARIANT_THREE},
		'{8'h05, 1'b1, SAFE_VARIANT_TWO}, '{8'h06, 1'b1, SAFE_VARIANT_ONE},
		'{8'h03, 1'b0, SAFE_VARIANT_NONE}, '{8'h97, 1'b0, SAFE_VARIANT_NONE}};
	imc_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
		.spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .spi_err_o(spi_err),
		.mode_init_i(mode_init), .mode_reprog_i(mode_reprog), .lp_req_i(lp_req),
		.lp_sel_on_i(lp_sel_on), .lp_code_i(lp_code), .lp_random_i(lp_random),
		.lowpower_regulator_off_o(lp_off), .lowpower_regulator_on_o(lp_on),
		.lp_reject_o(lp_rej), .int_req_i(int_req), .wd_half_i(wd_half), .int_ack_i(int_ack),
		.int_n_o(int_n), .res_check_en_o(res_en), .safe_variant_o(safe), .cfg_o(cfg));
	imc_master MST (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
	always #20 clk_i = ~clk_i;
	always @(negedge clk_i) begin
		if (spi_err === 1'b1) begin
			err_seen <= err_seen + 1;
		end
	end
	// serial answer as the master would take it
	always @(posedge sclk) begin
		if (cs_n === 1'b0) begin
			rd_sr <= {rd_sr[14:0], miso & miso_oe};
		end
	end
	task automatic end_sim();
		if (error_cnt == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk
	task automatic wr(input logic [7:0] d, input logic [1:0] pm);
		MST.send({`IMC_CMD_WRITE, `IMC_REG_ADDR, 1'b0, d}, pm, 16);
	endtask : wr
	task automatic lp(input logic sel, input logic [2:0] code, input logic [2:0] exp);
		logic [2:0] got;
		got = 3'h0;
		lp_sel_on = sel;
		lp_code = code;
		lp_req = 1'b1;
		@(negedge clk_i);
		lp_req = 1'b0;
		repeat (4) begin
			got = got | {lp_off, lp_on, lp_rej};
			@(negedge clk_i);
		end
		chk(got === exp, "low power answer");
	endtask : lp
	task automatic event_in(input logic wd);
		int_req = ~wd;
		wd_half = wd;
		@(negedge clk_i);
		int_req = 1'b0;
		wd_half = 1'b0;
	endtask : event_in
	task automatic pulse_len();
		n = 0;
		for (int i = 0; i < 20 && int_n !== 1'b0; i++) @(negedge clk_i);
		while (int_n === 1'b0 && n < 3000) begin
			n++;
			@(negedge clk_i);
		end
		if (n >= 3000) begin
			chk(1'b0, "interrupt stuck low");
			end_sim();
		end
	endtask : pulse_len
	initial begin
		{clk_i, resetn_i, mode_reprog, lp_req, lp_sel_on, int_req, wd_half, int_ack} = 8'h00;
		mode_init = 1'b1;
		lp_code = 3'h0;
		lp_random = 3'h5;
		repeat (16) @(negedge clk_i);
		resetn_i = 1'b1;
		chk(cfg === 8'h00 && int_n === 1'b1 && res_en === 1'b0, "reset state");
		for (int r = 0; r < 6; r++) begin
			wr(rows[r].data, 2'h0);
			chk(cfg === rows[r].data && res_en === rows[r].en && safe === rows[r].sv, "decode");
			chk(rd_sr === {8'h00, (r == 0) ? 8'h00 : rows[r - 1].data}, "read back");
		end
		mark = err_seen;
		MST.send({`IMC_CMD_READ, `IMC_REG_ADDR, 1'b0, 8'h55}, 2'h0, 16);
		chk(cfg === 8'h97 && rd_sr === 16'h0097 && miso_oe === 1'b0, "read frame");
		MST.send({`IMC_CMD_WRITE, 5'h09, 1'b0, 8'h55}, 2'h0, 16);
		chk(cfg === 8'h97 && err_seen == mark, "other address taken");
		MST.send({`IMC_CMD_WRITE, `IMC_REG_ADDR, 1'b0, 8'h3c}, 2'h0, 15);
		chk(cfg === 8'h97 && err_seen == mark + 1, "short frame taken");
		mode_init = 1'b0;
		wr(8'h05, 2'h0);
		chk(cfg === 8'h97, "write outside init");
		mode_init = 1'b1;
		wr(8'h40, 2'h0);
		mark = err_seen;
		wr(8'h44, 2'h2);
		chk(cfg === 8'h40 && err_seen == mark + 1, "bad parity taken");
		wr(8'h44, 2'h1);
		chk(cfg === 8'h44 && err_seen == mark + 1, "good parity refused");
		wr(8'h80, 2'h1);
		lp(1'b0, 3'h5, 3'b100);
		lp(1'b1, 3'h2, 3'b001);
		wr(8'h00, 2'h0);
		lp(1'b1, 3'h2, 3'b010);
		event_in(1'b0);
		pulse_len();
		chk(n == `IMC_INT_LONG_CYC, "long pulse width");
		wr(8'h10, 2'h0);
		event_in(1'b0);
		pulse_len();
		chk(n == `IMC_INT_SHORT_CYC, "short pulse width");
		wr(8'h20, 2'h0);
		event_in(1'b0);
		repeat (2600) @(negedge clk_i);
		chk(int_n === 1'b0, "level dropped");
		int_ack = 1'b1;
		@(negedge clk_i);
		int_ack = 1'b0;
		repeat (3) @(negedge clk_i);
		chk(int_n === 1'b1, "level not cleared");
		wr(8'h18, 2'h0);
		mode_reprog = 1'b1;
		event_in(1'b1);
		pulse_len();
		chk(n == `IMC_INT_SHORT_CYC, "half period pulse");
		wr(8'h10, 2'h0);
		event_in(1'b1);
		repeat (10) @(negedge clk_i);
		chk(int_n === 1'b1, "half period pulse disabled");
		resetn_i = 1'b0;
		repeat (2) @(negedge clk_i);
		resetn_i = 1'b1;
		chk(cfg === 8'h00 && safe === SAFE_VARIANT_NONE, "second reset");
		end_sim();
	end
endmodule : imc_top_tb
